/* File: shared/special_execute_field_pkg.sv */
// constants shared by the microword special-execute unit and its timers
package special_execute_field_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ          = 20;
	localparam int CLK_NS           = 50;
	localparam int MACHINE_CYCLE_NS = 200;
	localparam int MC_CLKS          = MACHINE_CYCLE_NS / CLK_NS;
	localparam int INHIBIT_INCR_MS  = 250;
	localparam int INHIBIT_CLKS     = INHIBIT_INCR_MS * 1000 * CLK_MHZ;
	localparam int BLOCK_MS         = 10;
	localparam int BLOCK_CLKS       = BLOCK_MS * 1000 * CLK_MHZ;
	localparam logic [1:0] PH_TAKE  = 2'h0;
	localparam logic [1:0] PH_EXEC  = 2'h3;

	// ************************************************************
	// register map (byte addresses) and reset values
	// ************************************************************
	localparam logic [4:0] OFS_LATCHES = 5'h00;
	localparam logic [4:0] OFS_DISPLAY = 5'h04;
	localparam logic [4:0] OFS_ADDRESS = 5'h08;
	localparam logic [4:0] OFS_CONTROL = 5'h0c;
	localparam int CTRL_RUN_BIT        = 0;
	localparam int CTRL_UNHALT_BIT     = 1;
	localparam logic CTRL_RUN_RESET    = 1'b1;

	// ************************************************************
	// special-execute codes
	// ************************************************************
	localparam logic [4:0] SX_CHANNEL_INTERFACE_ERROR_EN    = 5'h00;
	localparam logic [4:0] SX_REPEAT     = 5'h02;
	localparam logic [4:0] SX_ECC_ENABLE = 5'h03;
	localparam logic [4:0] SX_LOAD_DAR   = 5'h04;
	localparam logic [4:0] SX_LOAD_IAR   = 5'h05;
	localparam logic [4:0] SX_CLR_CMDQ   = 5'h06;
	localparam logic [4:0] SX_CLR_EXEC   = 5'h08;
	localparam logic [4:0] SX_ROUTINE    = 5'h09;
	localparam logic [4:0] SX_ERROR      = 5'h0a;
	localparam logic [4:0] SX_CASSETTE   = 5'h0b;
	localparam logic [4:0] SX_CAS_READ   = 5'h0e;
	localparam logic [4:0] SX_STOP       = 5'h0f;
	localparam logic [4:0] SX_CLR_CCHK   = 5'h10;
	localparam logic [4:0] SX_ECC_INHIB  = 5'h11;
	localparam logic [4:0] SX_CLR_BLOCK  = 5'h14;
	localparam logic [4:0] SX_INL_TIMER  = 5'h16;
	localparam logic [4:0] SX_SHIFT_P0   = 5'h17;
	localparam logic [4:0] SX_SHIFT_P123 = 5'h18;
	localparam logic [4:0] SX_READY      = 5'h1a;
	localparam logic [4:0] SX_END        = 5'h1b;
	localparam logic [4:0] SX_INTERRUPT  = 5'h1c;
	localparam logic [3:0] CS_DNZ        = 4'h9;
	localparam logic [2:0] ECC_ALLOW_WR  = 3'h7;
endpackage

/* File: hw/interval_timer.sv */
// counts a loaded number of fixed-length intervals and pulses when they are gone
module interval_timer
	import special_execute_field_pkg::*;
#(
	parameter int PERIOD = 4,
	parameter int CW     = 4
)
(
	input  wire logic          clk_sys_in,
	input  wire logic          rst_in,
	input  wire logic          load_in,
	input  wire logic [CW-1:0] count_in,
	output logic               running_out,
	output logic               expire_out
);
	localparam int PW = $clog2(PERIOD + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(PERIOD - 1);

	logic [PW-1:0] pre;
	logic [CW-1:0] left;

	// a reload restarts the whole span; zero intervals expire at once
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pre         <= '0;
			left        <= '0;
			running_out <= 1'b0;
			expire_out  <= 1'b0;
		end
		else
		begin
			expire_out <= 1'b0;
			if (load_in)
			begin
				pre         <= '0;
				left        <= count_in;
				running_out <= 1'b1;
			end
			else if (running_out && left == '0)
			begin
				running_out <= 1'b0;
				expire_out  <= 1'b1;
			end
			else if (running_out && pre == PRE_LAST)
			begin
				pre  <= '0;
				left <= left - 1'b1;
			end
			else if (running_out)
				pre <= pre + 1'b1;
		end
	end
endmodule // interval_timer

/* File: hw/microword_special_execute_unit.sv */
// microsequencer cycle timing, status-set decode and special-execute operations
// Notes on behaviour
// - the five-bit special-execute field picks one of twenty-one operations; the other eleven codes do nothing
// - code 00 enables channel error checks; enable drops while tag gate is low
// - code 02 sets repeat latch, which feeds the in-line branch condition
// - code 17 inhibits memory ECC check latches; code 03 re-enables them
// - code 04 copies B bus bits 5-7 into data address bits 1-3
// - code 05 copies B bus bits 1-7 into instruction address bits 1-7
// - code 08 clears the execute latch and the repeat latch
// - code 09 loads the routine-number register from the B register
// - code 10 loads the error-code register
// - code 11 loads cassette command latches and starts the cassette
// - code 14 ORs cassette read byte onto the D bus next machine cycle
// - code 16 clears control-fault latches; code 15 halts the machine
// - code 22 loads a count of 250 ms steps holding in-line branch false
// - code 22 bit 0 picks extended or temporary inhibit; extended blocks temporary
// - both inhibits clear on expiry; temporary also clears on channel selection
// - code 22 with bit 1 low blocks switching to picked channel 10 ms; 20 clears
// - code 23 shifts P0, plus P1-P3 if decode is 111; 24 shifts P1-P3
// - codes 26, 27, 28 raise ready, end with service request, interrupt
// - an instruction cycle takes one 200 ns machine cycle in fixed step order
// - fetch or store takes two machine cycles; decode inhibited in the second
module microword_special_execute_unit
	import special_execute_field_pkg::*;
#(
	parameter int INHIBIT_INCR_CLKS = INHIBIT_CLKS,
	parameter int BLOCK_SPAN_CLKS   = BLOCK_CLKS
)
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	input  wire logic        mw_valid_in,
	input  wire logic        mw_data_cycle_in,
	input  wire logic        mw_special_execute_field_in,
	input  wire logic [4:0]  special_execute_field_in,
	input  wire logic [3:0]  cs_code_in,
	input  wire logic [0:7]  b_bus_in,
	input  wire logic [0:7]  d_bus_in,
	input  wire logic        tag_gate_in,
	input  wire logic        channel_interface_error_in,
	input  wire logic        control_fault_in,
	input  wire logic        execute_switch_in,
	input  wire logic        function_inline_in,
	input  wire logic        command_query_in,
	input  wire logic        channel_selected_flag_in,
	input  wire logic        channel_pick_bit_in,
	input  wire logic [2:0]  ecc_decode_in,
	input  wire logic [0:7]  cassette_read_in,
	output logic             word_taken_out,
	output logic             decode_inhibit_out,
	output logic             cycle_done_out,
	output logic [0:7]       status_out,
	output logic [1:3]       data_address_reg_out,
	output logic [1:7]       instruction_address_reg_out,
	output logic             inline_branch_cond_out,
	output logic             command_query_branch_out,
	output logic             channel_interface_error_out,
	output logic             control_fault_out,
	output logic             ecc_check_inhibit_out,
	output logic [0:7]       cassette_cmd_out,
	output logic             cassette_start_out,
	output logic [0:7]       cassette_dbus_out,
	output logic             machine_halt_out,
	output logic             block_channel_out,
	output logic             block_channel_pick_out,
	output logic             ecc_shift_p0_out,
	output logic             ecc_shift_p123_out,
	output logic             ready_out,
	output logic             end_out,
	output logic             service_request_out,
	output logic [1:0]       interrupt_out
);
	// ************************************************************
	// machine cycle sequencing
	// ************************************************************
	logic [1:0] phase;
	logic       word_held;
	logic       held_data;
	logic       held_special_execute_field;
	logic [4:0] held_code;
	logic [3:0] held_cs;
	logic       second_cycle;
	logic       cas_gate;
	logic       run_enable;
	logic       channel_interface_error_enable;
	logic       repeat_latch;
	logic       execute_latch;
	logic       ext_inhibit;
	logic       temp_inhibit;
	logic [0:7] routine_reg;
	logic [0:7] error_reg;
	logic [0:7] next_status;

	// a word is taken only at phase 0 of a free machine cycle
	wire take_now = mw_valid_in && phase == PH_TAKE && !second_cycle
		&& run_enable && !machine_halt_out;
	wire exec_now = word_held && phase == PH_EXEC;
	wire data_end = second_cycle && phase == PH_EXEC;
	wire sx       = exec_now && held_special_execute_field;

	// one-hot special-execute decode, one wire per code
	wire [31:0] sx_hit = sx ? (32'h1 << held_code) : 32'h0;

	// phase counter runs free; four clocks make one 200 ns machine cycle
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end

	// step 1 latches the word; the rest resolve at the last phase
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			word_held    <= 1'b0;
			held_data    <= 1'b0;
			held_special_execute_field    <= 1'b0;
			held_code    <= 5'h00;
			held_cs      <= 4'h0;
			second_cycle <= 1'b0;
		end
		else
		begin
			if (take_now)
			begin
				word_held <= 1'b1;
				held_data <= mw_data_cycle_in;
				held_special_execute_field <= mw_special_execute_field_in;
				held_code <= special_execute_field_in;
				held_cs   <= cs_code_in;
			end
			else if (exec_now)
				word_held <= 1'b0;
			if (exec_now && held_data)
				second_cycle <= 1'b1;
			else if (data_end)
				second_cycle <= 1'b0;
		end
	end

	// ************************************************************
	// status-set decode
	// ************************************************************
	// returns {valid, value, bit index}
	function automatic logic [4:0] cs_map(input logic [3:0] code);
		case (code)
			4'h1: cs_map = 5'b10_100;
			4'h2: cs_map = 5'b10_001;
			4'h3: cs_map = 5'b11_001;
			4'h4: cs_map = 5'b10_000;
			4'h5: cs_map = 5'b11_000;
			4'h6: cs_map = 5'b10_101;
			4'h7: cs_map = 5'b11_101;
			4'h8: cs_map = 5'b10_010;
			4'ha: cs_map = 5'b10_011;
			4'hb: cs_map = 5'b11_011;
			4'hc: cs_map = 5'b10_110;
			4'hd: cs_map = 5'b11_110;
			4'he: cs_map = 5'b10_111;
			4'hf: cs_map = 5'b11_111;
			default: cs_map = 5'b00_000;
		endcase
	endfunction

	wire [4:0] cs_sel   = cs_map(held_cs);
	wire       cs_apply = exec_now && !held_special_execute_field && cs_sel[4];
	wire       dnz_set  = exec_now && !held_special_execute_field && held_cs == CS_DNZ
		&& d_bus_in != 8'h00;

	always_comb
	begin
		next_status = status_out;
		if (cs_apply)
			next_status[cs_sel[2:0]] = cs_sel[3];
		if (dnz_set)
			next_status[2] = 1'b1;
	end

	// ************************************************************
	// in-line timers
	// ************************************************************
	wire load_inl  = sx_hit[SX_INL_TIMER];
	wire load_blk  = load_inl && !b_bus_in[1];
	wire inl_done;
	wire blk_done;
	wire blk_run;

	interval_timer #(.PERIOD(INHIBIT_INCR_CLKS), .CW(4)) u_inline_timer
	(
		.clk_sys_in  (clk_sys_in),
		.rst_in      (rst_in),
		.load_in     (load_inl),
		.count_in    (b_bus_in[4:7]),
		.running_out (),
		.expire_out  (inl_done)
	);

	interval_timer #(.PERIOD(BLOCK_SPAN_CLKS), .CW(1)) u_block_timer
	(
		.clk_sys_in  (clk_sys_in),
		.rst_in      (rst_in),
		.load_in     (load_blk),
		.count_in    (1'b1),
		.running_out (blk_run),
		.expire_out  (blk_done)
	);

	// ************************************************************
	// register bus
	// ************************************************************
	wire bus_req   = (avs_read_in || avs_write_in) && avs_waitrequest_out;
	wire wr_fire   = avs_write_in && !avs_waitrequest_out;
	wire ctrl_wr   = wr_fire && avs_address_in == OFS_CONTROL && avs_byteenable_in[0];
	wire unhalt    = ctrl_wr && avs_writedata_in[CTRL_UNHALT_BIT];
	wire [31:0] latches_word = {21'h0, blk_run, machine_halt_out, block_channel_out,
		ext_inhibit, temp_inhibit, command_query_branch_out, ecc_check_inhibit_out,
		repeat_latch, execute_latch, channel_interface_error_enable, control_fault_out};
	wire [31:0] rd_mux =
		avs_address_in == OFS_LATCHES ? latches_word :
		avs_address_in == OFS_DISPLAY ? {8'h0, cassette_cmd_out, error_reg, routine_reg} :
		avs_address_in == OFS_ADDRESS ?
			{13'h0, data_address_reg_out, instruction_address_reg_out, 1'b0, status_out} :
		avs_address_in == OFS_CONTROL ? {31'h0, run_enable} : 32'h0;

	// every access answers after one wait cycle; unmapped reads return zero
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out    <= 32'h0;
			run_enable          <= CTRL_RUN_RESET;
		end
		else
		begin
			avs_waitrequest_out <= !bus_req;
			if (bus_req)
				avs_readdata_out <= rd_mux;
			if (ctrl_wr)
				run_enable <= avs_writedata_in[CTRL_RUN_BIT];
		end
	end

	// ************************************************************
	// special-execute latches and registers
	// ************************************************************
	// hardware-set flags win over a clear landing in the same clock
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			channel_interface_error_enable                 <= 1'b0;
			repeat_latch                <= 1'b0;
			execute_latch               <= 1'b0;
			ext_inhibit                 <= 1'b0;
			temp_inhibit                <= 1'b0;
			command_query_branch_out    <= 1'b0;
			channel_interface_error_out <= 1'b0;
			control_fault_out           <= 1'b0;
			ecc_check_inhibit_out       <= 1'b0;
			machine_halt_out            <= 1'b0;
			block_channel_out           <= 1'b0;
			block_channel_pick_out      <= 1'b0;
		end
		else
		begin
			// tag gate low holds the enable clear over any set
			if (!tag_gate_in)
				channel_interface_error_enable <= 1'b0;
			else if (sx_hit[SX_CHANNEL_INTERFACE_ERROR_EN])
				channel_interface_error_enable <= 1'b1;
			if (channel_interface_error_enable && channel_interface_error_in)
				channel_interface_error_out <= 1'b1;
			else if (sx_hit[SX_CLR_CCHK])
				channel_interface_error_out <= 1'b0;
			if (control_fault_in)
				control_fault_out <= 1'b1;
			else if (sx_hit[SX_CLR_CCHK])
				control_fault_out <= 1'b0;
			if (sx_hit[SX_REPEAT])
				repeat_latch <= 1'b1;
			else if (sx_hit[SX_CLR_EXEC])
				repeat_latch <= 1'b0;
			if (execute_switch_in && function_inline_in)
				execute_latch <= 1'b1;
			else if (sx_hit[SX_CLR_EXEC])
				execute_latch <= 1'b0;
			if (command_query_in)
				command_query_branch_out <= 1'b1;
			else if (sx_hit[SX_CLR_CMDQ])
				command_query_branch_out <= 1'b0;
			if (sx_hit[SX_ECC_INHIB])
				ecc_check_inhibit_out <= 1'b1;
			else if (sx_hit[SX_ECC_ENABLE])
				ecc_check_inhibit_out <= 1'b0;
			if (sx_hit[SX_STOP])
				machine_halt_out <= 1'b1;
			else if (unhalt)
				machine_halt_out <= 1'b0;
			if (load_inl && b_bus_in[0])
				ext_inhibit <= 1'b1;
			else if (inl_done)
				ext_inhibit <= 1'b0;
			if (load_inl && !b_bus_in[0] && !ext_inhibit)
				temp_inhibit <= 1'b1;
			else if (inl_done || channel_selected_flag_in)
				temp_inhibit <= 1'b0;
			if (load_blk)
			begin
				block_channel_out      <= 1'b1;
				block_channel_pick_out <= channel_pick_bit_in;
			end
			else if (sx_hit[SX_CLR_BLOCK] || blk_done)
				block_channel_out <= 1'b0;
		end
	end

	// register loads, channel tags and the data-path strobes
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_out                  <= 8'h00;
			data_address_reg_out        <= 3'h0;
			instruction_address_reg_out <= 7'h00;
			routine_reg                 <= 8'h00;
			error_reg                   <= 8'h00;
			cassette_cmd_out            <= 8'h00;
			cassette_start_out          <= 1'b0;
			cas_gate                    <= 1'b0;
			cassette_dbus_out           <= 8'h00;
			inline_branch_cond_out      <= 1'b0;
			ecc_shift_p0_out            <= 1'b0;
			ecc_shift_p123_out          <= 1'b0;
			ready_out                   <= 1'b0;
			end_out                     <= 1'b0;
			service_request_out         <= 1'b0;
			interrupt_out               <= 2'h0;
			word_taken_out              <= 1'b0;
			decode_inhibit_out          <= 1'b0;
			cycle_done_out              <= 1'b0;
		end
		else
		begin
			status_out <= next_status;
			if (sx_hit[SX_LOAD_DAR])
				data_address_reg_out <= b_bus_in[5:7];
			if (sx_hit[SX_LOAD_IAR])
				instruction_address_reg_out <= b_bus_in[1:7];
			if (sx_hit[SX_ROUTINE])
				routine_reg <= b_bus_in;
			if (sx_hit[SX_ERROR])
				error_reg <= b_bus_in;
			if (sx_hit[SX_CASSETTE])
				cassette_cmd_out <= b_bus_in;
			cassette_start_out <= sx_hit[SX_CASSETTE];
			// the gate spans exactly the following machine cycle
			if (sx_hit[SX_CAS_READ])
				cas_gate <= 1'b1;
			else if (phase == PH_EXEC)
				cas_gate <= 1'b0;
			cassette_dbus_out <= cas_gate ? cassette_read_in : 8'h00;
			inline_branch_cond_out <= (repeat_latch || execute_latch)
				&& !ext_inhibit && !temp_inhibit;
			ecc_shift_p0_out   <= sx_hit[SX_SHIFT_P0];
			ecc_shift_p123_out <= sx_hit[SX_SHIFT_P123]
				|| (sx_hit[SX_SHIFT_P0] && ecc_decode_in == ECC_ALLOW_WR);
			ready_out           <= sx_hit[SX_READY];
			end_out             <= sx_hit[SX_END];
			service_request_out <= sx_hit[SX_END];
			interrupt_out <= sx_hit[SX_INTERRUPT] ?
				(channel_pick_bit_in ? 2'h2 : 2'h1) : 2'h0;
			word_taken_out     <= take_now;
			decode_inhibit_out <= second_cycle || (exec_now && held_data);
			cycle_done_out     <= (exec_now && !held_data) || data_end;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_taken;
		take_now;
	endsequence
	sequence s_exec;
		exec_now;
	endsequence

	property p_cycle;
		@(posedge clk_sys_in) disable iff (rst_in) s_taken |-> ##3 s_exec;
	endproperty
	a_cycle: assert property (p_cycle) else $error("word not executed 3 clocks after take");

	property p_data;
		@(posedge clk_sys_in) disable iff (rst_in)
			(exec_now && held_data) |=> decode_inhibit_out [*4] ##1 !second_cycle;
	endproperty
	a_data: assert property (p_data) else $error("data cycle second half wrong");

	property p_st2;
		@(posedge clk_sys_in) disable iff (rst_in) dnz_set |=> status_out[2];
	endproperty
	a_st2: assert property (p_st2) else $error("status bit two not set");

	property p_channel_interface_error;
		@(posedge clk_sys_in) disable iff (rst_in) !tag_gate_in |=> !channel_interface_error_enable;
	endproperty
	a_channel_interface_error: assert property (p_channel_interface_error) else $error("check enable held without tag gate");

	property p_dar;
		@(posedge clk_sys_in) disable iff (rst_in)
			sx_hit[SX_LOAD_DAR] |=> data_address_reg_out == $past(b_bus_in[5:7]);
	endproperty
	a_dar: assert property (p_dar) else $error("data address quadrant not loaded");

	property p_iar;
		@(posedge clk_sys_in) disable iff (rst_in)
			sx_hit[SX_LOAD_IAR] |=> instruction_address_reg_out == $past(b_bus_in[1:7]);
	endproperty
	a_iar: assert property (p_iar) else $error("instruction address not loaded");

	property p_clear_exec;
		@(posedge clk_sys_in) disable iff (rst_in)
			(sx_hit[SX_CLR_EXEC] && !(execute_switch_in && function_inline_in))
			|=> !repeat_latch && !execute_latch;
	endproperty
	a_clear_exec: assert property (p_clear_exec) else $error("latches not cleared");

	property p_inhibit;
		@(posedge clk_sys_in) disable iff (rst_in)
			(ext_inhibit || temp_inhibit) |=> !inline_branch_cond_out;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("in-line branch not held false");

	property p_ext_first;
		@(posedge clk_sys_in) disable iff (rst_in)
			(load_inl && !b_bus_in[0] && ext_inhibit) |=> !$rose(temp_inhibit);
	endproperty
	a_ext_first: assert property (p_ext_first) else $error("temporary set under extended");

	property p_nop;
		@(posedge clk_sys_in) disable iff (rst_in)
			(sx && (held_code == 5'h07 || held_code >= 5'h1d)) |=>
			$stable(routine_reg) && $stable(instruction_address_reg_out) && !ready_out;
	endproperty
	a_nop: assert property (p_nop) else $error("unused code changed state");
endmodule // microword_special_execute_unit

/* File: testbench/mw_source.sv */
// microprogram memory model: offers one word per request and holds it
module mw_source
(
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic [4:0] code_in,
	input  wire logic [0:7] b_in,
	input  wire logic       taken_in,
	input  wire logic       done_in,
	output logic            valid_out,
	output logic [4:0]      field_out,
	output logic [0:7]      b_bus_out,
	output logic            busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// word held until taken, b bus until the cycle ends, then inverted so stale data shows
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			{valid_out, busy_out, field_out, b_bus_out} <= '0;
		else if (start_in)
			{valid_out, busy_out, field_out, b_bus_out} <= {2'b11, code_in, b_in};
		else
		begin
			if (taken_in)
				valid_out <= 1'b0;
			if (done_in)
				{busy_out, b_bus_out} <= {1'b0, ~b_bus_out};
		end
	end
endmodule // mw_source

/* File: testbench/tb.sv */
// self-checking bench for the special-execute unit
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module tb
	import special_execute_field_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk, rst, start, dcyc, special_execute_field, rd, wr;
	logic [4:0] code, adr, fld;
	logic [0:7] bb, dbus, cr, b, cas_seen, status, ccmd, cdb, bbus;
	logic [7:0] ctl;
	logic [3:0] cs;
	logic [2:0] eccd;
	logic [31:0] wdat, q, rdata;
	logic [1:3] data_address_reg;
	logic [1:7] instruction_address_reg;
	logic [1:0] intr;
	logic       wait_r, valid, busy, taken, dinh, done, inl, cqb, cf, ecci, cstart, halt, blk;
	logic       p0, p123, rdy, endp, srq, cie, bpick;
	int         bad_count, num_checks, n_rdy, n_end, n_srq, n_int, n_p0, n_p3, n_cs, n_di;
	int         cnt, len;
	logic [4:0] nop [6] = '{5'h07, 5'h12, 5'h13, 5'h1d, 5'h1e, 5'h1f};
	microword_special_execute_unit #(.INHIBIT_INCR_CLKS(8), .BLOCK_SPAN_CLKS(400)) dut_u (
		.clk_sys_in(clk), .rst_in(rst), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wait_r), .mw_valid_in(valid),
		.mw_data_cycle_in(dcyc), .mw_special_execute_field_in(special_execute_field), .special_execute_field_in(fld),
		.cs_code_in(cs), .b_bus_in(bbus), .d_bus_in(dbus), .tag_gate_in(ctl[0]),
		.channel_interface_error_in(ctl[1]), .control_fault_in(ctl[2]),
		.execute_switch_in(ctl[3]), .function_inline_in(ctl[4]), .command_query_in(ctl[5]),
		.channel_selected_flag_in(ctl[6]), .channel_pick_bit_in(ctl[7]), .ecc_decode_in(eccd),
		.cassette_read_in(cr), .word_taken_out(taken), .decode_inhibit_out(dinh),
		.cycle_done_out(done), .status_out(status), .data_address_reg_out(data_address_reg),
		.instruction_address_reg_out(instruction_address_reg), .inline_branch_cond_out(inl),
		.command_query_branch_out(cqb), .channel_interface_error_out(cie), .control_fault_out(cf),
		.ecc_check_inhibit_out(ecci), .cassette_cmd_out(ccmd), .cassette_start_out(cstart),
		.cassette_dbus_out(cdb), .machine_halt_out(halt), .block_channel_out(blk),
		.block_channel_pick_out(bpick), .ecc_shift_p0_out(p0), .ecc_shift_p123_out(p123),
		.ready_out(rdy), .end_out(endp), .service_request_out(srq), .interrupt_out(intr));
	mw_source src_u (.clk_sys_in(clk), .rst_in(rst), .start_in(start), .code_in(code),
		.b_in(bb), .taken_in(taken), .done_in(done), .valid_out(valid),
		.field_out(fld), .b_bus_out(bbus), .busy_out(busy));
	// ************************************************************
	// clock, tallies and bus tasks
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// flops are read in the active region, before this edge's updates land
	always @(posedge clk)
	begin
		n_rdy += rdy;
		n_end += endp;
		n_srq += srq;
		n_int += intr;
		n_p0 += p0;
		n_p3 += p123;
		n_cs += cstart;
		n_di += dinh;
		cas_seen |= cdb;
		cnt = taken ? 0 : cnt + 1;
		if (done)
			len = cnt;
	end
	// a stuck word or bus access is left to the watchdog, which fails the run
	task automatic wd(input logic [4:0] c, input logic [0:7] v);
		{code, bb, start} <= {c, v, 1'b1};
		@(posedge clk);
		start <= 1'b0;
		do @(negedge clk); while (busy !== 1'b0);
		@(posedge clk);
	endtask
	// request held until the rising edge that samples waitrequest low
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
		{adr, wdat, wr, rd} <= {a, d, w, !w};
		do @(posedge clk); while (wait_r !== 1'b0);
		q = rdata;
		{wr, rd} <= 2'b00;
		@(posedge clk);
	endtask
	task automatic wrap_up();
		$display("mismatches %0d of %0d checks", bad_count, num_checks);
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// watchdog far beyond the expected run of several hundred clocks
	initial
	begin
		#2000000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		{start, dcyc, rd, wr, ctl, cs, eccd, dbus, cr, code, bb, adr, wdat, cas_seen} = '0;
		{special_execute_field, rst} = 2'b11;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		void'($urandom(32'h2bc1));
		`CHK(wait_r, 1'b1)
		av(0, OFS_CONTROL, 0);
		`CHK(q[0], CTRL_RUN_RESET)
		av(0, 5'h10, 0);
		`CHK(q, 32'h0)
		repeat (3)
		begin
			b = 8'($urandom);
			wd(SX_LOAD_DAR, b);
			`CHK(data_address_reg, b[5:7])
			wd(SX_LOAD_IAR, b);
			`CHK(instruction_address_reg, b[1:7])
			wd(SX_ROUTINE, b);
			wd(SX_ERROR, ~b);
			wd(SX_CASSETTE, b);
			`CHK(ccmd, b)
			av(0, OFS_DISPLAY, 0);
			`CHK(q[15:0], {~b, b})
		end
		`CHK(n_cs, 3)
		foreach (nop[i])
		begin
			wd(nop[i], ~b);
			`CHK({data_address_reg, instruction_address_reg, ccmd}, {b[5:7], b[1:7], b})
		end
		wd(SX_REPEAT, 0);
		`CHK(inl, 1'b1)
		ctl[4:3] <= 2'b11;
		@(posedge clk);
		ctl[4:3] <= 2'b00;
		wd(SX_CLR_EXEC, 0);
		`CHK(inl, 1'b0)
		wd(SX_ECC_INHIB, 0);
		`CHK(ecci, 1'b1)
		wd(SX_ECC_ENABLE, 0);
		`CHK(ecci, 1'b0)
		ctl[7] <= 1'b1;
		wd(SX_READY, 0);
		wd(SX_END, 0);
		wd(SX_INTERRUPT, 0);
		`CHK({n_rdy, n_end, n_srq, n_int}, {32'd1, 32'd1, 32'd1, 32'd2})
		eccd <= ECC_ALLOW_WR;
		wd(SX_SHIFT_P0, 0);
		eccd <= 3'h0;
		wd(SX_SHIFT_P0, 0);
		wd(SX_SHIFT_P123, 0);
		`CHK({n_p0, n_p3}, {32'd2, 32'd2})
		ctl[0] <= 1'b1;
		wd(SX_CHANNEL_INTERFACE_ERROR_EN, 0);
		av(0, OFS_LATCHES, 0);
		`CHK(q[1], 1'b1)
		ctl[2:0] <= 3'b111;
		@(posedge clk);
		ctl[2:0] <= 3'b000;
		@(posedge clk);
		`CHK({cf, cie}, 2'b11)
		av(0, OFS_LATCHES, 0);
		`CHK(q[1], 1'b0)
		wd(SX_CLR_CCHK, 0);
		`CHK({cf, cie}, 2'b00)
		ctl[1] <= 1'b1;
		@(posedge clk);
		ctl[1] <= 1'b0;
		@(posedge clk);
		`CHK(cie, 1'b0)
		wd(SX_STOP, 0);
		`CHK(halt, 1'b1)
		av(1, OFS_CONTROL, 32'h3);
		`CHK(halt, 1'b0)
		ctl[5] <= 1'b1;
		@(posedge clk);
		ctl[5] <= 1'b0;
		repeat (MC_CLKS) @(posedge clk);
		`CHK(cqb, 1'b1)
		wd(SX_CLR_CMDQ, 0);
		`CHK(cqb, 1'b0)
		{special_execute_field, cs, dbus} <= {1'b0, CS_DNZ, 8'h01 | 8'($urandom)};
		wd(5'h07, 0);
		`CHK(status[2], 1'b1)
		{special_execute_field, cr} <= {1'b1, 8'($urandom)};
		wd(SX_CAS_READ, 0);
		wd(5'h07, 0);
		`CHK(cas_seen, cr)
		`CHK(len, MC_CLKS - 1)
		dcyc <= 1'b1;
		wd(5'h07, 0);
		dcyc <= 1'b0;
		`CHK(len, 2 * MC_CLKS - 1)
		`CHK(n_di, 5)
		wd(SX_REPEAT, 0);
		wd(SX_INL_TIMER, 8'h02);
		`CHK({inl, blk, bpick}, 3'b011)
		repeat (40) @(posedge clk);
		`CHK(inl, 1'b1)
		wd(SX_CLR_BLOCK, 0);
		`CHK(blk, 1'b0)
		wd(SX_INL_TIMER, 8'hcf);
		wd(SX_INL_TIMER, 8'h4f);
		av(0, OFS_LATCHES, 0);
		`CHK(q[7:6], 2'b10)
		ctl[6] <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(inl, 1'b0)
		ctl[6] <= 1'b0;
		repeat (200) @(posedge clk);
		wd(SX_INL_TIMER, 8'h4f);
		ctl[6] <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(inl, 1'b1)
		wrap_up();
	end
endmodule // tb
